// ==== lofs_pkg.sv ====
package lofs_pkg;
  // register byte addresses
  localparam logic [11:0] OFS_OUT_CFG = 12'h080;
  localparam logic [11:0] OFS_IF_CFG = 12'h084;
  // writable bits and reset values
  localparam logic [31:0] OUT_CFG_MASK = 32'h0007FFFF;
  localparam logic [31:0] IF_CFG_MASK = 32'h03800000;
  localparam logic [31:0] OUT_CFG_RST = 32'h00000000;
  localparam logic [31:0] IF_CFG_RST = 32'h00000000;
  // field positions
  localparam int DEST_LSB = 0;
  localparam int INTF_LSB = 2;
  localparam int PFMT_LSB = 5;
  localparam int BFMT_LSB = 8;
  localparam int SFMT_LSB = 10;
  localparam int DIRECT_BIT = 17;
  localparam int ENDIAN_BIT = 18;
  localparam int RST_BIT = 23;
  localparam int DDLY_BIT = 24;
  localparam int CDLY_BIT = 25;
  // destinations
  localparam logic [1:0] DEST_PANEL0 = 2'h0;
  localparam logic [1:0] DEST_PANEL1 = 2'h1;
  localparam logic [1:0] DEST_BUS_DISP = 2'h2;
  localparam logic [1:0] DEST_BUS_MEM = 2'h3;
  // interface types
  localparam logic [2:0] INTF_PAR_B = 3'h0;
  localparam logic [2:0] INTF_SERIAL = 3'h1;
  localparam logic [2:0] INTF_CMD_BRIDGE = 3'h2;
  localparam logic [2:0] INTF_RGB = 3'h3;
  localparam logic [2:0] INTF_MIP_SER = 3'h4;
  localparam logic [2:0] INTF_MIP_PAR = 3'h5;
  localparam logic [2:0] INTF_PAR_A = 3'h6;
  localparam logic [2:0] INTF_VID_BRIDGE = 3'h7;
  // panel formats
  localparam logic [2:0] PFMT_332 = 3'h0;
  localparam logic [2:0] PFMT_565_8 = 3'h1;
  localparam logic [2:0] PFMT_444 = 3'h2;
  localparam logic [2:0] PFMT_565 = 3'h3;
  localparam logic [2:0] PFMT_666 = 3'h4;
  localparam logic [2:0] PFMT_888 = 3'h5;
  localparam logic [2:0] PFMT_888_16 = 3'h6;
  localparam logic [2:0] PFMT_888_8 = 3'h7;
  // serial panel formats
  localparam logic [1:0] SFMT_332 = 2'h0;
  localparam logic [1:0] SFMT_565 = 2'h1;
  localparam logic [1:0] SFMT_888 = 2'h2;
  // bus formats
  localparam logic [1:0] BFMT_565 = 2'h0;
  localparam logic [1:0] BFMT_888 = 2'h1;
  localparam logic [1:0] BFMT_ARGB = 2'h2;
  localparam logic [1:0] BFMT_332 = 2'h3;
  localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // output sinks
  typedef enum logic [1:0] {SINK_NONE, SINK_PANEL, SINK_BUS, SINK_BRIDGE} lofs_sink_e;
  // incoming pixel
  typedef struct packed {
    logic valid;
    logic [23:0] rgb;
  } lofs_pix_s;
  // panel control outputs
  typedef struct packed {
    logic strobe;
    logic [1:0] cs;
    logic last;
  } lofs_ctrl_s;
  // whole module state
  typedef struct packed {
    logic [31:0] out_cfg;
    logic [31:0] if_cfg;
    logic [31:0] rdata;
    logic [1:0][23:0] buf_mem;
    logic buf_rd;
    logic [1:0] buf_cnt;
    logic [1:0] phase;
    logic [7:0] hold_b;
    logic [31:0] word;
    logic word_valid;
    lofs_sink_e word_sink;
    lofs_ctrl_s ctrl;
    logic [23:0] pd1;
    lofs_ctrl_s pc1;
  } lofs_state_s;
endpackage

// ==== lofs_top.sv ====
`timescale 1ns/100ps
module lofs_top (
  input wire logic clock, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire lofs_pkg::lofs_pix_s pix_in, // pixel in
  output logic pix_ready, // pixel accept
  output logic [23:0] panel_data, // panel data pins
  output lofs_pkg::lofs_ctrl_s panel_ctrl, // panel control pins
  output logic panel_reset_pin, // panel reset pin
  output logic [31:0] bus_word, // bus sink word
  output logic bus_valid, // bus sink valid
  input wire logic bus_ready, // bus sink ready
  output logic [31:0] bridge_word, // bridge sink word
  output logic bridge_valid, // bridge sink valid
  input wire logic bridge_ready // bridge sink ready
);

  lofs_pkg::lofs_state_s s; // registered state
  lofs_pkg::lofs_state_s next_s; // next state
  logic [1:0] sel; // decoded register
  logic [1:0] dest; // destination field
  logic [2:0] intf; // interface field
  logic [2:0] pfmt; // panel format
  logic [1:0] sfmt; // serial format
  logic [1:0] bfmt; // bus format
  logic [23:0] head; // oldest buffered pixel
  logic [15:0] c565; // head as 565
  lofs_pkg::lofs_sink_e sink; // current sink
  logic out_free; // output reg can load
  logic fmt_ok; // format is defined
  logic emit; // beat issued this cycle
  logic pop; // head consumed
  logic push; // pixel accepted
  logic [31:0] beat; // formatted beat
  logic last; // final beat of a pixel
  logic [1:0] nphase; // beat index after this one
  logic [7:0] nhold; // held blue after this one

  // register select decode: 1 output cfg, 2 interface cfg, 0 unmapped
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    if (a == lofs_pkg::OFS_OUT_CFG) begin
      reg_sel = 2'h1;
    end else if (a == lofs_pkg::OFS_IF_CFG) begin
      reg_sel = 2'h2;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // 565 packing, endian bit reorders fields to low green, red, blue, high green
  function automatic logic [15:0] to565(input logic [23:0] p, input logic swap);
    logic [4:0] r;
    logic [5:0] g;
    logic [4:0] b;
    r = p[23:19];
    g = p[15:10];
    b = p[7:3];
    if (swap) begin
      to565 = {g[2:0], r, b, g[5:3]};
    end else begin
      to565 = {r, g, b};
    end
  endfunction

  // 332 packing
  function automatic logic [7:0] to332(input logic [23:0] p);
    to332 = {p[23:21], p[15:13], p[7:6]};
  endfunction

  // field views and apb answer
  assign sel = reg_sel(paddr);
  assign dest = s.out_cfg[lofs_pkg::DEST_LSB +: 2];
  assign intf = s.out_cfg[lofs_pkg::INTF_LSB +: 3];
  assign pfmt = s.out_cfg[lofs_pkg::PFMT_LSB +: 3];
  assign sfmt = s.out_cfg[lofs_pkg::SFMT_LSB +: 2];
  assign bfmt = s.out_cfg[lofs_pkg::BFMT_LSB +: 2];
  assign head = s.buf_mem[s.buf_rd];
  assign c565 = to565(head, s.out_cfg[lofs_pkg::ENDIAN_BIT]);
  assign prdata = s.rdata;
  // registers answer at once, so the access phase never waits
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == 2'h0);
  // back-pressure only once both buffer entries hold a pixel
  assign pix_ready = (s.buf_cnt != lofs_pkg::BUF_DEPTH);
  assign push = pix_in.valid & pix_ready;
  assign panel_reset_pin = s.if_cfg[lofs_pkg::RST_BIT];

  // sink choice from destination and interface type
  always_comb begin
    if (dest == lofs_pkg::DEST_BUS_DISP) begin
      sink = s.out_cfg[lofs_pkg::DIRECT_BIT] ? lofs_pkg::SINK_BRIDGE : lofs_pkg::SINK_BUS;
    end else if (dest == lofs_pkg::DEST_BUS_MEM) begin
      sink = lofs_pkg::SINK_BUS;
    end else if (intf == lofs_pkg::INTF_CMD_BRIDGE || intf == lofs_pkg::INTF_VID_BRIDGE) begin
      sink = lofs_pkg::SINK_BRIDGE;
    end else begin
      sink = lofs_pkg::SINK_PANEL;
    end
  end

  // beat formatter: one bus beat per cycle from the buffer head
  always_comb begin
    beat = 32'h0;
    last = 1'b1;
    fmt_ok = 1'b1;
    nphase = 2'h0;
    nhold = s.hold_b;
    // the bridge takes raw pixels and formats them itself
    if (sink == lofs_pkg::SINK_BRIDGE) begin
      beat = {8'h0, head};
    end else if (sink == lofs_pkg::SINK_BUS) begin
      case (bfmt)
        lofs_pkg::BFMT_565: beat = {16'h0, c565};
        lofs_pkg::BFMT_888: beat = {8'h0, head};
        lofs_pkg::BFMT_ARGB: beat = {lofs_pkg::ALPHA_OPAQUE, head};
        default: beat = {24'h0, to332(head)};
      endcase
    end else if (intf == lofs_pkg::INTF_SERIAL) begin
      case (sfmt)
        lofs_pkg::SFMT_332: beat = {24'h0, to332(head)};
        lofs_pkg::SFMT_565: beat = {16'h0, c565};
        lofs_pkg::SFMT_888: beat = {8'h0, head};
        default: fmt_ok = 1'b0;
      endcase
    end else begin
      case (pfmt)
        lofs_pkg::PFMT_332: beat = {24'h0, to332(head)};
        lofs_pkg::PFMT_565_8: begin
          beat = {24'h0, (s.phase == 2'h0) ? c565[15:8] : c565[7:0]};
          last = (s.phase != 2'h0);
          nphase = last ? 2'h0 : 2'h1;
        end
        lofs_pkg::PFMT_444: beat = {20'h0, head[23:20], head[15:12], head[7:4]};
        lofs_pkg::PFMT_565: beat = {16'h0, c565};
        lofs_pkg::PFMT_666: beat = {14'h0, head[23:18], head[15:10], head[7:2]};
        lofs_pkg::PFMT_888: beat = {8'h0, head};
        // phase 0 parks blue so the next beat can pair it with red
        lofs_pkg::PFMT_888_16: begin
          case (s.phase)
            2'h0: begin
              beat = {16'h0, head[23:8]};
              nhold = head[7:0];
              nphase = 2'h1;
            end
            2'h1: begin
              beat = {16'h0, s.hold_b, head[23:16]};
              last = 1'b0;
              nphase = 2'h2;
            end
            default: beat = {16'h0, head[15:0]};
          endcase
        end
        default: begin
          case (s.phase)
            2'h0: beat = {24'h0, head[23:16]};
            2'h1: beat = {24'h0, head[15:8]};
            default: beat = {24'h0, head[7:0]};
          endcase
          last = (s.phase == 2'h2);
          nphase = last ? 2'h0 : s.phase + 2'h1;
        end
      endcase
    end
  end

  // output register may load when empty or its sink takes the word
  always_comb begin
    case (s.word_sink)
      lofs_pkg::SINK_BUS: out_free = ~s.word_valid | bus_ready;
      lofs_pkg::SINK_BRIDGE: out_free = ~s.word_valid | bridge_ready;
      default: out_free = 1'b1;
    endcase
  end
  // a reserved format stalls the stream rather than emit garbage
  assign emit = (s.buf_cnt != 2'h0) & out_free & fmt_ok;
  assign pop = emit & last;

  // next state
  always_comb begin
    next_s = s;
    if (psel & penable & pwrite & (sel == 2'h1)) begin // output cfg write
      next_s.out_cfg = pwdata & lofs_pkg::OUT_CFG_MASK;
    end else if (psel & penable & pwrite & (sel == 2'h2)) begin // interface cfg write
      next_s.if_cfg = pwdata & lofs_pkg::IF_CFG_MASK;
    end
    if (psel & ~penable) begin // read data fetched in setup
      if (sel == 2'h1) begin
        next_s.rdata = s.out_cfg;
      end else if (sel == 2'h2) begin
        next_s.rdata = s.if_cfg;
      end else begin
        next_s.rdata = 32'h0;
      end
    end
    // with one entry held, the free slot is the one opposite the head
    if (push) begin // write behind the head
      next_s.buf_mem[s.buf_rd ^ s.buf_cnt[0]] = pix_in.rgb;
    end
    if (pop) begin // drop the head
      next_s.buf_rd = ~s.buf_rd;
    end
    next_s.buf_cnt = s.buf_cnt + {1'b0, push} - {1'b0, pop};
    if (emit) begin // load a fresh beat
      next_s.word = beat;
      next_s.word_valid = 1'b1;
      next_s.word_sink = sink;
      next_s.phase = nphase;
      next_s.hold_b = nhold;
      next_s.ctrl.strobe = (sink == lofs_pkg::SINK_PANEL);
      next_s.ctrl.cs = (dest == lofs_pkg::DEST_PANEL1) ? 2'h2 : 2'h1;
      next_s.ctrl.last = last;
    end else if (out_free) begin // word taken, nothing new
      next_s.word_valid = 1'b0;
      next_s.ctrl.strobe = 1'b0;
    end
    // extra stage always runs; the config bits only pick it
    next_s.pd1 = s.word[23:0];
    next_s.pc1 = s.ctrl;
  end

  // state register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // pin and sink outputs, optional extra stage
  assign panel_data = s.if_cfg[lofs_pkg::DDLY_BIT] ? s.pd1 : s.word[23:0];
  assign panel_ctrl = s.if_cfg[lofs_pkg::CDLY_BIT] ? s.pc1 : s.ctrl;
  assign bus_word = s.word;
  assign bus_valid = s.word_valid & (s.word_sink == lofs_pkg::SINK_BUS);
  assign bridge_word = s.word;
  assign bridge_valid = s.word_valid & (s.word_sink == lofs_pkg::SINK_BRIDGE);

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // register side
  property p_rst_pin;
    psel && penable && pwrite && paddr == lofs_pkg::OFS_IF_CFG |=> panel_reset_pin == $past(pwdata[23]);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin missed write");
  // output delay stages
  property p_ddly;
    s.if_cfg[lofs_pkg::DDLY_BIT] && $past(s.if_cfg[lofs_pkg::DDLY_BIT]) |-> panel_data == $past(s.word[23:0]);
  endproperty
  a_ddly: assert property (p_ddly) else $error("data delay wrong");
  property p_cdly;
    emit && sink == lofs_pkg::SINK_PANEL && s.if_cfg[lofs_pkg::CDLY_BIT] && !s.ctrl.strobe
      |=> !panel_ctrl.strobe ##1 panel_ctrl.strobe;
  endproperty
  a_cdly: assert property (p_cdly) else $error("control delay wrong");
  // routing
  property p_mem;
    emit && dest == lofs_pkg::DEST_BUS_MEM |=> bus_valid && !bridge_valid && !panel_ctrl.strobe;
  endproperty
  a_mem: assert property (p_mem) else $error("memory beat misrouted");
  property p_direct;
    emit && dest == lofs_pkg::DEST_BUS_DISP && s.out_cfg[lofs_pkg::DIRECT_BIT] |=> bridge_valid && !bus_valid;
  endproperty
  a_direct: assert property (p_direct) else $error("direct path unused");
  property p_brg;
    emit && !dest[1] && (intf == lofs_pkg::INTF_CMD_BRIDGE || intf == lofs_pkg::INTF_VID_BRIDGE) |=> bridge_valid;
  endproperty
  a_brg: assert property (p_brg) else $error("bridge code misrouted");
  property p_brg_word;
    emit && sink == lofs_pkg::SINK_BRIDGE |=> bridge_valid && bridge_word == {8'h00, $past(head)};
  endproperty
  a_brg_word: assert property (p_brg_word) else $error("bridge word wrong");
  // pixel packing
  property p_b888;
    emit && sink == lofs_pkg::SINK_PANEL && intf != lofs_pkg::INTF_SERIAL && pfmt == lofs_pkg::PFMT_888_8
      && s.phase == 2'h0 && !pop |=> s.word[7:0] == $past(head[23:16]) && s.buf_cnt != 2'h0;
  endproperty
  a_b888: assert property (p_b888) else $error("byte 888 order wrong");
  property p_h888;
    emit && sink == lofs_pkg::SINK_PANEL && intf != lofs_pkg::INTF_SERIAL && pfmt == lofs_pkg::PFMT_888_16
      && s.phase == 2'h0 |=> s.word[15:0] == $past(head[23:8]) && s.phase == 2'h1;
  endproperty
  a_h888: assert property (p_h888) else $error("halfword 888 wrong");
  property p_argb;
    emit && sink == lofs_pkg::SINK_BUS && bfmt == lofs_pkg::BFMT_ARGB |=> s.word[31:24] == lofs_pkg::ALPHA_OPAQUE;
  endproperty
  a_argb: assert property (p_argb) else $error("argb alpha wrong");
  property p_ser;
    emit && sink == lofs_pkg::SINK_PANEL && intf == lofs_pkg::INTF_SERIAL && sfmt == lofs_pkg::SFMT_565
      |=> s.word[31:16] == 16'h0 && s.word[15:0] == $past(c565);
  endproperty
  a_ser: assert property (p_ser) else $error("serial 565 wrong");
  property p_b565;
    emit && sink == lofs_pkg::SINK_PANEL && intf != lofs_pkg::INTF_SERIAL && pfmt == lofs_pkg::PFMT_565_8
      && s.phase == 2'h0 |=> s.word[7:0] == $past(c565[15:8]);
  endproperty
  a_b565: assert property (p_b565) else $error("byte 565 order wrong");
  property p_swap;
    emit && sink == lofs_pkg::SINK_PANEL && intf != lofs_pkg::INTF_SERIAL && pfmt == lofs_pkg::PFMT_565
      && s.out_cfg[lofs_pkg::ENDIAN_BIT] |=> s.word[15:0] == {$past(head[12:10]), $past(head[23:19]),
      $past(head[7:3]), $past(head[15:13])};
  endproperty
  a_swap: assert property (p_swap) else $error("swapped 565 order wrong");
  // buffer and stream handshakes
  property p_cnt;
    s.buf_cnt <= lofs_pkg::BUF_DEPTH;
  endproperty
  a_cnt: assert property (p_cnt) else $error("buffer overfilled");
  property p_bus_hold;
    bus_valid && !bus_ready |=> bus_valid && $stable(bus_word);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus word dropped");
  property p_brg_hold;
    bridge_valid && !bridge_ready |=> bridge_valid && $stable(bridge_word);
  endproperty
  a_brg_hold: assert property (p_brg_hold) else $error("bridge word dropped");
  // scenario coverage
  c_full: cover property (s.buf_cnt == lofs_pkg::BUF_DEPTH && !pix_ready);
  c_bridge: cover property (bridge_valid && !bridge_ready ##1 bridge_valid);
  c_three: cover property (emit && pfmt == lofs_pkg::PFMT_888_8 ##1 emit ##1 pop);
  c_delay: cover property (panel_ctrl.strobe && s.if_cfg[lofs_pkg::CDLY_BIT]);
  c_swap: cover property (emit && s.out_cfg[lofs_pkg::ENDIAN_BIT] && sink == lofs_pkg::SINK_PANEL);

endmodule

// ==== lofs_sink.sv ====
`timescale 1ns/100ps
// far-side consumer of one valid/ready word stream (panel, bus or bridge)
module lofs_sink (
  input wire logic clock, // controller clock
  input wire logic nrst, // sync reset, active low
  input wire logic valid, // word offered
  input wire logic [31:0] word, // offered word
  input wire logic stall, // consumer holds off
  input wire logic slow, // consumer takes every other cycle
  output logic ready // consumer ready
);
  logic [31:0] rx[$]; // words taken, oldest first
  logic tick = 1'b0; // alternates for slow mode
  // slow mode offers ready only on every second cycle
  assign ready = nrst & ~stall & (~slow | tick);
  // a word is taken only at an edge where valid and ready are both high
  always @(posedge clock) begin
    tick <= nrst ? ~tick : 1'b0;
    if (valid && ready) begin
      rx.push_back(word);
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
// self-checking bench for the output format select block
module tb;
  typedef struct {logic [31:0] cfg; int sk, n, p; logic [31:0] b[3];} lofs_row_s;
  localparam logic [23:0] PIX = 24'hA53CE1; // r a5, g 3c, b e1
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, pix_ready, panel_reset_pin;
  logic bus_valid, bus_ready, bridge_valid, bridge_ready, stall, slow, e;
  logic [11:0] paddr; // apb address
  logic [31:0] pwdata, prdata, bus_word, bridge_word, q;
  logic [23:0] panel_data; // panel pins
  logic [1:0] last_cs; // chip select of latest beat
  lofs_pkg::lofs_pix_s pix_in; // pixel source
  lofs_pkg::lofs_ctrl_s panel_ctrl; // panel control pins
  int miscompares, samples_checked, cyc, t_acc, t_out, nlast, a, l0, l1, l2;
  lofs_row_s rows[$]; // ordinary cases
  lofs_top i_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pix_in, .pix_ready, .panel_data, .panel_ctrl, .panel_reset_pin, .bus_word, .bus_valid, .bus_ready,
    .bridge_word, .bridge_valid, .bridge_ready);
  lofs_sink i_pan (.clock, .nrst, .valid(panel_ctrl.strobe), .word({8'h00, panel_data}), .stall(1'b0),
    .slow(1'b0), .ready());
  lofs_sink i_bus (.clock, .nrst, .valid(bus_valid), .word(bus_word), .stall, .slow, .ready(bus_ready));
  lofs_sink i_brg (.clock, .nrst, .valid(bridge_valid), .word(bridge_word), .stall, .slow, .ready(bridge_ready));
  // verdict and end of run
  task stop_test;
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one comparison
  task chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(logic w, logic [11:0] ad, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (!pready);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(logic [11:0] ad, logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rd(logic [11:0] ad, logic [31:0] exp, logic err);
    apb(1'b0, ad, 32'h00000000);
    chk(q, exp);
    chk(e, err);
  endtask
  // offer one pixel until it is taken
  task send(logic [23:0] v);
    @(posedge clock);
    pix_in <= '{1'b1, v};
    do @(posedge clock); while (!pix_ready);
    pix_in.valid <= 1'b0;
  endtask
  // keep offering numbered pixels for eight edges, count how many are taken
  task fill(output int n);
    n = 0;
    @(posedge clock);
    pix_in <= '{1'b1, 24'h000001};
    repeat (8) begin
      @(posedge clock);
      if (pix_ready) begin
        n++;
        pix_in.rgb <= 24'(n + 1);
      end
    end
    pix_in.valid <= 1'b0;
  endtask
  task clr;
    i_pan.rx.delete(); i_bus.rx.delete(); i_brg.rx.delete();
    nlast = 0;
  endtask
  // cycles from taking a pixel to its first panel strobe
  task lat(logic [23:0] v, output int l);
    clr();
    t_out = 0;
    send(v);
    for (int w = 0; w < 20 && t_out == 0; w++) @(posedge clock);
    @(negedge clock); // let the panel sink take its word
    l = t_out - t_acc;
  endtask
  function automatic int qn(int s);
    case (s) 0: return i_pan.rx.size(); 1: return i_bus.rx.size(); default: return i_brg.rx.size(); endcase
  endfunction
  function automatic logic [31:0] qv(int s, int i);
    case (s) 0: return i_pan.rx[i]; 1: return i_bus.rx[i]; default: return i_brg.rx[i]; endcase
  endfunction
  function automatic logic [31:0] mk(int d, int i, int p, int b = 0, int s = 0, int x = 0);
    return 32'(d | (i << 2) | (p << 5) | (b << 8) | (s << 10) | x);
  endfunction
  function automatic lofs_row_s r(logic [31:0] c, int sk, int n, int p, logic [31:0] b0, b1 = 0, b2 = 0);
    r.cfg = c; r.sk = sk; r.n = n; r.p = p; r.b = '{b0, b1, b2};
  endfunction
  // clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // cycle count, latency marks, beat bookkeeping and hang guard
  always @(posedge clock) begin
    cyc++;
    if (pix_in.valid && pix_ready) t_acc = cyc;
    if (panel_ctrl.strobe) begin
      if (t_out == 0) t_out = cyc;
      last_cs = panel_ctrl.cs;
      nlast += panel_ctrl.last;
    end
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pix_in = 0; stall = 0; slow = 0;
    // sink: 0 panel, 1 bus, 2 bridge; beats for two equal pixels, period p
    rows = {r(mk(0,0,0),0,2,1,32'hA7), r(mk(0,0,1),0,4,2,32'hA1,32'hFC), r(mk(0,0,2),0,2,1,32'hA3E),
      r(mk(0,0,3),0,2,1,32'hA1FC), r(mk(0,0,4),0,2,1,32'h293F8), r(mk(0,0,5),0,2,1,32'hA53CE1),
      r(mk(0,0,6),0,3,3,32'hA53C,32'hE1A5,32'h3CE1), r(mk(0,0,7),0,6,3,32'hA5,32'h3C,32'hE1),
      r(mk(0,0,3,0,0,1<<18),0,2,1,32'hF4E1), r(mk(1,6,5),0,2,1,32'hA53CE1), r(mk(0,3,5),0,2,1,32'hA53CE1),
      r(mk(0,4,5),0,2,1,32'hA53CE1), r(mk(0,5,5),0,2,1,32'hA53CE1), r(mk(0,1,0,0,0),0,2,1,32'hA7),
      r(mk(0,1,0,0,1),0,2,1,32'hA1FC), r(mk(0,1,0,0,2),0,2,1,32'hA53CE1), r(mk(2,0,0,0),1,2,1,32'hA1FC),
      r(mk(2,0,0,1),1,2,1,32'hA53CE1), r(mk(2,0,0,2),1,2,1,32'hFFA53CE1), r(mk(3,0,0,3),1,2,1,32'hA7),
      r(mk(2,0,0,0,0,1<<17),2,2,1,32'hA53CE1), r(mk(0,2,5),2,2,1,32'hA53CE1), r(mk(0,7,5),2,2,1,32'hA53CE1)};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    rd(lofs_pkg::OFS_OUT_CFG, lofs_pkg::OUT_CFG_RST, 1'b0);
    rd(lofs_pkg::OFS_IF_CFG, lofs_pkg::IF_CFG_RST, 1'b0);
    wr(lofs_pkg::OFS_OUT_CFG, 32'hFFFFFFFF);
    rd(lofs_pkg::OFS_OUT_CFG, lofs_pkg::OUT_CFG_MASK, 1'b0);
    wr(lofs_pkg::OFS_IF_CFG, 32'hFFFFFFFF);
    rd(lofs_pkg::OFS_IF_CFG, lofs_pkg::IF_CFG_MASK, 1'b0);
    @(negedge clock) chk(panel_reset_pin, 1'b1);
    wr(lofs_pkg::OFS_IF_CFG, 32'h00000000);
    @(negedge clock) chk(panel_reset_pin, 1'b0);
    rd(12'h088, 32'h00000000, 1'b1);
    // ordinary cases from the table
    foreach (rows[k]) begin
      wr(lofs_pkg::OFS_OUT_CFG, rows[k].cfg);
      clr();
      slow <= 1'(k % 2);
      send(PIX);
      send(PIX);
      for (int w = 0; w < 60 && qn(rows[k].sk) < rows[k].n; w++) @(posedge clock);
      repeat (4) @(posedge clock);
      chk(qn(0) + qn(1) + qn(2), rows[k].n);
      for (int i = 0; i < rows[k].n; i++) chk(qv(rows[k].sk, i), rows[k].b[i % rows[k].p]);
      if (rows[k].sk == 0) begin
        chk(last_cs, rows[k].cfg[0] ? 2 : 1);
        chk(nlast, 2);
      end
    end
    // extra output delays
    wr(lofs_pkg::OFS_OUT_CFG, mk(0,0,5));
    lat(PIX, l0);
    chk(l0, 2);
    wr(lofs_pkg::OFS_IF_CFG, 32'h02000000);
    lat(PIX, l1);
    chk(l1, l0 + 1);
    wr(lofs_pkg::OFS_IF_CFG, 32'h03000000);
    lat(PIX, l2);
    chk(l2, l0 + 1);
    chk(qv(0, 0), {8'h00, PIX});
    // data delay alone: the strobe still meets the previous data, the new pixel a cycle later
    wr(lofs_pkg::OFS_IF_CFG, 32'h01000000);
    lat(24'h5A0F3C, l1);
    chk(l1, l0);
    chk(qv(0, 0), {8'h00, PIX});
    chk(panel_data, 24'h5A0F3C);
    wr(lofs_pkg::OFS_IF_CFG, 32'h00000000);
    // full buffer under a stalled bus, then a slow drain in order
    wr(lofs_pkg::OFS_OUT_CFG, mk(3,0,0,1));
    clr();
    stall <= 1'b1;
    fill(a);
    @(negedge clock);
    chk(a, 3);
    chk(bus_valid, 1'b1);
    @(posedge clock);
    stall <= 1'b0;
    slow <= 1'b1;
    for (int w = 0; w < 30 && qn(1) < 3; w++) @(posedge clock);
    for (int i = 0; i < 3; i++) chk(qv(1, i), 32'(i + 1));
    repeat (3) @(posedge clock);
    @(negedge clock) chk(bus_valid, 1'b0);
    // reserved serial format emits nothing and the buffer fills
    wr(lofs_pkg::OFS_OUT_CFG, mk(0,1,0,0,3));
    clr();
    fill(a);
    repeat (4) @(posedge clock);
    chk(a, 2);
    chk(qn(0) + qn(1) + qn(2), 0);
    // second reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(negedge clock) chk(pix_ready, 1'b1);
    rd(lofs_pkg::OFS_OUT_CFG, lofs_pkg::OUT_CFG_RST, 1'b0);
    stop_test();
  end
endmodule
